/* File: bench/async_tx_fifo_threshold_ctrl_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; $display("unexpected %0t: %h %h", $time, a, e); end end
module async_tx_fifo_threshold_ctrl_test;
  import atf_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0, dma_go = 1'b0;
  logic underrun = 1'b0, tx_done = 1'b0, hready, hresp, go, sf, mpeg, dv, prio, irq, pkt_start, eop;
  logic pipe, accel;
  logic [1:0] htrans = 2'h0;
  logic [7:0] fmt = 8'h00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, want, d, rnd = 32'h6e2c_30fa;
  logic [11:0] len = 12'h07C0, step = 12'h0040, fill;
  logic [11:0] lvl [4] = '{LVL_2K, LVL_1K7, LVL_1K, LVL_512};
  logic [31:0] exp_q[$];
  int fail_count = 0, checks_done = 0;
  always #50 clk_in = ~clk_in;
  atf_tx_ctrl #(.FILL_W(12)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .fifo_fill_in(fill), .pkt_start_in(pkt_start),
    .eop_loaded_in(eop), .underrun_in(underrun), .tx_done_in(tx_done), .cip_fmt_in(fmt), .tx_go_out(go),
    .sf_mode_out(sf), .mpeg_stamp_fix_on_out(mpeg), .dv_stamp_fix_on_out(dv), .prio_arb_out(prio),
    .pipe_dis_out(pipe), .accel_on_out(accel), .irq_out(irq));
  atf_dma_model i_dma (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_in(dma_go), .len_in(len),
    .step_in(step), .fill_out(fill), .pkt_start_out(pkt_start), .eop_out(eop));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    if (!wr) exp_q.push_back(dat);
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge clk_in); while (hready !== 1'b1);
  endtask
  task automatic wait_go(input logic [11:0] w);
    for (int n = 0; n < 200 && go !== 1'b1; n++) @(posedge clk_in);
    `CHK(fill, w)
  endtask
  // Rewrites the threshold mid-packet: the latched one must still rule
  task automatic packet(input logic [1:0] c, input logic [11:0] w);
    bus(1'b1, ADDR_LINK_ENH, 32'(c) << THRESH_LSB);
    dma_go <= 1'b1;
    @(posedge clk_in);
    dma_go <= 1'b0;
    bus(1'b1, ADDR_LINK_ENH, 32'(c ^ 2'h1) << THRESH_LSB);
    wait_go(w);
  endtask
  task automatic done();
    tx_done <= 1'b1;
    @(posedge clk_in);
    tx_done <= 1'b0;
  endtask
  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (rd_ph && hready === 1'b1) begin
      want = exp_q.pop_front();
      `CHK(hrdata, want)
    end
    if (hready === 1'b1) rd_ph <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    bus(1'b0, ADDR_LINK_ENH, 32'h0000_1000);
    bus(1'b0, ADDR_RETRY_CNT, 32'h0000_0000);
    bus(1'b0, 8'h10, 32'h0000_0000);
    packet(2'h3, len);
    done();
    bus(1'b1, ADDR_RETRY_CNT, 32'h0000_0003);
    for (int c = 3; c >= 0; c--) begin
      packet(2'(c), c == 0 ? len : lvl[c] + step);
      done();
    end
    packet(2'h3, lvl[3] + step);
    step <= 12'h0000;
    underrun <= 1'b1;
    @(posedge clk_in);
    underrun <= 1'b0;
    repeat (3) @(posedge clk_in);
    `CHK(sf, 1'b1)
    step <= 12'h0040;
    wait_go(len);
    done();
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      fmt <= i == 0 ? FMT_MPEG : i == 1 ? FMT_DV : rnd[23:16];
      d = i == 2 ? rnd : rnd | 32'h0000_0580;
      bus(1'b1, ADDR_LINK_ENH, d);
      bus(1'b0, ADDR_LINK_ENH, d & LINK_ENH_WMASK);
      `CHK({prio, mpeg, dv}, {d[7], d[10] && fmt == FMT_MPEG, d[8] && fmt == FMT_DV})
      `CHK({pipe, accel}, {d[PIPE_DIS_BIT], d[ACCEL_BIT]})
    end
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0000_0003);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 1'b1)
    bus(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 1'b0)
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0000_0002);
    complete_run();
  end
endmodule

/* File: bench/atf_dma_model.sv */
`timescale 1ns/1ps
module atf_dma_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire logic [11:0] len_in,
  input wire logic [11:0] step_in,
  output logic [11:0] fill_out,
  output logic pkt_start_out,
  output logic eop_out
);
  // Step of zero stalls the fill, as a slow host bus would
  always_ff @(posedge clk_in) begin
    pkt_start_out <= start_in & reset_n_in;
    if (!reset_n_in || start_in) begin
      fill_out <= 12'h0000;
      eop_out <= 1'b0;
    end else if (fill_out + step_in >= len_in) begin
      fill_out <= len_in;
      eop_out <= 1'b1;
    end else begin
      fill_out <= fill_out + step_in;
    end
  end
endmodule

/* File: bench/atf_tx_ctrl_assertions.sv */
`timescale 1ns/1ps
module atf_tx_ctrl_assertions
  import atf_pkg::*;
#(
  parameter int FILL_W = 12
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [FILL_W-1:0] fifo_fill_in,
  input wire logic eop_loaded_in,
  input wire logic [7:0] cip_fmt_in,
  input wire logic tx_go_out,
  input wire logic sf_mode_out,
  input wire logic mpeg_stamp_fix_on_out,
  input wire logic dv_stamp_fix_on_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_ready_high: assert property (hreadyout_out) else $error("ready dropped");
  a_resp_okay: assert property (!hresp_out) else $error("error response");
  a_go_pulse: assert property (tx_go_out |=> !tx_go_out) else $error("go held");
  a_sf_waits_eop: assert property (tx_go_out && sf_mode_out |-> $past(eop_loaded_in))
    else $error("store-forward go before end token");
  a_go_cause: assert property (tx_go_out |-> $past(eop_loaded_in) || $past(fifo_fill_in) >= FILL_W'(LVL_512))
    else $error("go without cause");
  a_mpeg_fmt: assert property (mpeg_stamp_fix_on_out |-> $past(cip_fmt_in) == FMT_MPEG)
    else $error("mpeg fix on wrong format");
  a_dv_fmt: assert property (dv_stamp_fix_on_out |-> $past(cip_fmt_in) == FMT_DV)
    else $error("dv fix on wrong format");
  a_resv_zero: assert property (hsel_in && hready_in && htrans_in[1] && !hwrite_in &&
    haddr_in[7:0] == ADDR_LINK_ENH |=> (hrdata_out & ~LINK_ENH_WMASK) == 32'h0000_0000) else $error("reserved bit set");
  c_go_sf: cover property (tx_go_out && sf_mode_out);
  c_go_part: cover property (tx_go_out && !sf_mode_out);
  c_irq: cover property (irq_out);
endmodule
bind atf_tx_ctrl atf_tx_ctrl_assertions #(.FILL_W(FILL_W)) i_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .fifo_fill_in(fifo_fill_in),
  .eop_loaded_in(eop_loaded_in), .cip_fmt_in(cip_fmt_in), .tx_go_out(tx_go_out), .sf_mode_out(sf_mode_out),
  .mpeg_stamp_fix_on_out(mpeg_stamp_fix_on_out), .dv_stamp_fix_on_out(dv_stamp_fix_on_out), .irq_out(irq_out));

/* File: rtl/atf_thr_dec.sv */
`timescale 1ns/1ps
module atf_thr_dec
  import atf_pkg::*;
(
  atf_thr_if.dec thr
);
  // ****************************************
  // Threshold code to start level
  // ****************************************
  always_comb begin
    if (thr.sf_force) begin
      thr.level = LVL_2K;
    end else begin
      unique case (thr.thresh_code)
        THR_STORE_FWD: thr.level = LVL_2K;
        THR_1K7: thr.level = LVL_1K7;
        THR_1K: thr.level = LVL_1K;
        THR_512: thr.level = LVL_512;
      endcase
    end
  end
endmodule

/* File: rtl/atf_tx_ctrl.sv */
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Function
// - Threshold code 00=2K store-forward, 01=1.7K, 10=1K, 11=512 bytes.
// - Threshold field resets to 01, about 1.7K bytes.
// - Programmed threshold holds until underrun; retries use 2K store-and-forward.
// - Partial threshold: start at threshold fill or whole packet loaded, first wins.
// - After underrun use store-and-forward; retry waits for whole packet.
// - 2K threshold sends nothing until end-of-packet token arrives.
// - Retry count zero forces store-and-forward regardless of threshold.
// - Bit 10 enables MPEG timestamp fix for format 20h streams.
// - Bit 8 enables DV timestamp fix for format 00h streams.
// - Bit 7 makes link answer requests with priority arbitration.
// - Reserved bits 11 and 9 read zero, writes ignored.
module atf_tx_ctrl
  import atf_pkg::*;
#(
  parameter int FILL_W = 12
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [FILL_W-1:0] fifo_fill_in,
  input wire logic pkt_start_in,
  input wire logic eop_loaded_in,
  input wire logic underrun_in,
  input wire logic tx_done_in,
  input wire logic [7:0] cip_fmt_in,
  output logic tx_go_out,
  output logic sf_mode_out,
  output logic mpeg_stamp_fix_on_out,
  output logic dv_stamp_fix_on_out,
  output logic prio_arb_out,
  output logic pipe_dis_out,
  output logic accel_on_out,
  output logic irq_out
);
  // ****************************************
  // Bus slave
  // ****************************************
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  logic [31:0] link_enh;
  logic [3:0] retry_cnt;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;
  logic [IRQ_WIDTH-1:0] irq_event;
  logic [IRQ_WIDTH-1:0] irq_clear;
  logic addr_take;
  logic [31:0] next_rdata;

  typedef enum logic [1:0] {ATF_IDLE, ATF_FILL, ATF_SEND, ATF_RETRY} atf_state_t;
  atf_state_t state;
  logic [1:0] pkt_thresh;
  logic retry_sf;
  logic start_now;
  logic [11:0] fill_bytes;

  atf_thr_if thr ();

  assign addr_take = hsel_in && hready_in && htrans_in[1];

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend <= addr_take && hwrite_in;
      rd_pend <= addr_take && !hwrite_in;
      if (addr_take) begin
        addr_q <= haddr_in[7:0];
      end
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (haddr_in[7:0])
      ADDR_LINK_ENH: next_rdata = link_enh;
      ADDR_RETRY_CNT: next_rdata = {28'h000_0000, retry_cnt};
      ADDR_IRQ_STATUS: next_rdata = {30'h0000_0000, irq_status};
      ADDR_IRQ_MASK: next_rdata = {30'h0000_0000, irq_mask};
      ADDR_TX_STATUS: next_rdata = {27'h000_0000, retry_sf, sf_mode_out, tx_go_out, pkt_thresh};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data launched with the address so it stands in the data phase
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (addr_take && !hwrite_in) begin
      hrdata_out <= next_rdata;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      link_enh <= LINK_ENH_RESET;
    end else if (wr_pend && addr_q == ADDR_LINK_ENH) begin
      link_enh <= hwdata_in & LINK_ENH_WMASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      retry_cnt <= RETRY_RESET;
    end else if (wr_pend && addr_q == ADDR_RETRY_CNT) begin
      retry_cnt <= hwdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irq_mask <= '0;
    end else if (wr_pend && addr_q == ADDR_IRQ_MASK) begin
      irq_mask <= hwdata_in[IRQ_WIDTH-1:0];
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_clear = (wr_pend && addr_q == ADDR_IRQ_STATUS) ? hwdata_in[IRQ_WIDTH-1:0] : '0;
  assign irq_event = {start_now, underrun_in && state == ATF_SEND};

  // Set wins over a same-cycle clear
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((irq_status & ~irq_clear) | irq_event) & irq_mask);
    end
  end

  // ****************************************
  // Transmit start control
  // ****************************************
  assign thr.thresh_code = pkt_thresh;
  assign thr.sf_force = retry_sf || (retry_cnt == 4'h0);

  atf_thr_dec u_dec (
    .thr(thr)
  );

  // Fill widened or cut on purpose to the 12-bit level scale
  assign fill_bytes = 12'(fifo_fill_in);

  // Store-and-forward waits for end of packet; partial waits for level or end
  always_comb begin
    if (thr.level == LVL_2K) begin
      start_now = (state == ATF_FILL || state == ATF_RETRY) && eop_loaded_in;
    end else begin
      start_now = state == ATF_FILL && (eop_loaded_in || fill_bytes >= thr.level);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= ATF_IDLE;
      pkt_thresh <= THR_1K7;
      retry_sf <= 1'b0;
    end else begin
      unique case (state)
        ATF_IDLE: begin
          if (pkt_start_in) begin
            pkt_thresh <= link_enh[THRESH_LSB +: 2];
            retry_sf <= 1'b0;
            state <= ATF_FILL;
          end
        end
        ATF_FILL: begin
          if (start_now) begin
            state <= ATF_SEND;
          end
        end
        ATF_SEND: begin
          // Underrun sends the packet to a store-and-forward retry
          if (underrun_in) begin
            retry_sf <= 1'b1;
            state <= ATF_RETRY;
          end else if (tx_done_in) begin
            state <= ATF_IDLE;
          end
        end
        ATF_RETRY: begin
          if (start_now) begin
            state <= ATF_SEND;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      tx_go_out <= 1'b0;
      sf_mode_out <= 1'b0;
    end else begin
      tx_go_out <= start_now;
      sf_mode_out <= thr.level == LVL_2K;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mpeg_stamp_fix_on_out <= 1'b0;
      dv_stamp_fix_on_out <= 1'b0;
      prio_arb_out <= 1'b0;
      pipe_dis_out <= 1'b0;
      accel_on_out <= 1'b0;
    end else begin
      mpeg_stamp_fix_on_out <= link_enh[MPEG_BIT] && cip_fmt_in == FMT_MPEG;
      dv_stamp_fix_on_out <= link_enh[DV_BIT] && cip_fmt_in == FMT_DV;
      prio_arb_out <= link_enh[PRIO_BIT];
      pipe_dis_out <= link_enh[PIPE_DIS_BIT];
      accel_on_out <= link_enh[ACCEL_BIT];
    end
  end
endmodule

/* File: shared/atf_pkg.sv */
package atf_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_LINK_ENH = 8'hF4;
  localparam logic [7:0] ADDR_RETRY_CNT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;
  localparam logic [7:0] ADDR_TX_STATUS = 8'h48;

  // ****************************************
  // Link enhancement control fields
  // ****************************************
  localparam int THRESH_LSB = 12;
  localparam int MPEG_BIT = 10;
  localparam int DV_BIT = 8;
  localparam int PRIO_BIT = 7;
  localparam int PIPE_DIS_BIT = 15;
  localparam int ACCEL_BIT = 1;
  localparam logic [31:0] LINK_ENH_WMASK = 32'h0000_B582;
  localparam logic [31:0] LINK_ENH_RESET = 32'h0000_1000;
  localparam logic [3:0] RETRY_RESET = 4'h0;

  // ****************************************
  // Threshold codes and levels in bytes
  // ****************************************
  localparam logic [1:0] THR_STORE_FWD = 2'h0;
  localparam logic [1:0] THR_1K7 = 2'h1;
  localparam logic [1:0] THR_1K = 2'h2;
  localparam logic [1:0] THR_512 = 2'h3;
  localparam logic [11:0] LVL_2K = 12'h0800;
  localparam logic [11:0] LVL_1K7 = 12'h06C0;
  localparam logic [11:0] LVL_1K = 12'h0400;
  localparam logic [11:0] LVL_512 = 12'h0200;

  // ****************************************
  // CIP format codes
  // ****************************************
  localparam logic [7:0] FMT_MPEG = 8'h20;
  localparam logic [7:0] FMT_DV = 8'h00;

  // ****************************************
  // Interrupt bits
  // ****************************************
  localparam int IRQ_UNDERRUN = 0;
  localparam int IRQ_TX_START = 1;
  localparam int IRQ_WIDTH = 2;
endpackage

/* File: shared/atf_thr_if.sv */
`timescale 1ns/1ps
interface atf_thr_if;
  logic [1:0] thresh_code;
  logic sf_force;
  logic [11:0] level;
  modport ctrl (output thresh_code, output sf_force, input level);
  modport dec (input thresh_code, input sf_force, output level);
endinterface
